// >>> rtl/mcr_pkg.sv
// What this block does
// - Reset input clears all logic without clock
// - Transmit clock strobes derive from reference clock
// - Held in reset while lock input low
// - Attributes loaded at power-up and reset
// - True attribute is 1, false is 0
// - Mode attributes fixed after loading
// - Other attributes are host-rewritable register defaults
// - Host registers reachable only when host-enabled
// - Both enabled: serial management follows register bit
// - Transmit client width 16 or 8
// - Receive client width 16 or 8
// - No select true gives MII/GMII mode
// - Select reduced, serial or fiber interface
// - Speed pattern picks 1000, 100, 10
package mcr_pkg;

    // ********************************
    // Register map
    // ********************************
    localparam int MCR_ADR_W = 4;
    localparam logic [MCR_ADR_W-1:0] MCR_REG_MODE = 4'h0;
    localparam logic [MCR_ADR_W-1:0] MCR_REG_MGMT = 4'h4;
    localparam logic [MCR_ADR_W-1:0] MCR_REG_STAT = 4'h8;

    // Mode register fields
    localparam int MCR_MODE_HOST = 0;
    localparam int MCR_MODE_MDIO_ATTR = 1;
    localparam int MCR_MODE_TXW = 2;
    localparam int MCR_MODE_RXW = 3;
    localparam int MCR_MODE_PHY_LO = 4;
    localparam int MCR_MODE_SPD_LO = 30;
    // Management register field
    localparam int MCR_MGMT_MDIO = 6;
    // Status register fields
    localparam int MCR_STAT_LOCK = 0;
    localparam int MCR_STAT_RUN = 1;
    localparam int MCR_STAT_SEL_FAULT = 2;
    localparam int MCR_STAT_SPD_FAULT = 3;

    localparam logic [31:0] MCR_ZERO_WORD = 32'h0000_0000;

    // ********************************
    // Speed codes and dividers
    // ********************************
    localparam logic [1:0] MCR_SPD_10 = 2'h0;
    localparam logic [1:0] MCR_SPD_100 = 2'h1;
    localparam logic [1:0] MCR_SPD_1000 = 2'h2;
    localparam logic [1:0] MCR_SPD_NA = 2'h3;
    localparam int MCR_DIV_100 = 5;
    localparam int MCR_DIV_10 = 50;
    localparam int MCR_DIV_W = 6;

    // ********************************
    // Types
    // ********************************
    typedef struct packed {
        logic host_interface_enable_attr;
        logic mgmt_serial_enable_attr;
        logic tx_wide_client_attr;
        logic rx_wide_client_attr;
        logic reduced_gig_if_select_attr;
        logic serial_gig_if_select_attr;
        logic fiber_gig_if_select_attr;
        logic speed_msb_attr;
        logic speed_lsb_attr;
    } mcr_attr_t;

    typedef enum logic [3:0] {
        MCR_PHY_MII_GMII = 4'h1,
        MCR_PHY_REDUCED = 4'h2,
        MCR_PHY_SERIAL = 4'h4,
        MCR_PHY_FIBER = 4'h8
    } mcr_phy_t;

    typedef struct packed {
        logic host_en;
        logic mdio_attr;
        logic tx_wide;
        logic rx_wide;
        mcr_phy_t phy;
    } mcr_mode_t;

    typedef enum logic [2:0] {
        MCR_ST_HOLD = 3'h1,
        MCR_ST_LOAD = 3'h2,
        MCR_ST_RUN = 3'h4
    } mcr_state_t;

endpackage

// >>> rtl/mcr_reset_sync.sv
`timescale 1ns/1ps
`default_nettype none
module mcr_reset_sync
    import mcr_pkg::*;
(
    input wire logic sys_clk, // System clock
    input wire logic clk_en, // Freezes state when low
    input wire logic async_rst, // Reset request, any time
    output logic sync_rst // Asserts at once, releases on clock
);
    logic stage1;

    always_ff @(posedge sys_clk or posedge async_rst) begin
        if (async_rst) begin
            stage1 <= 1'b1;
            sync_rst <= 1'b1;
        end else if (clk_en) begin
            stage1 <= 1'b0;
            sync_rst <= stage1;
        end
    end
endmodule
`default_nettype wire

// >>> rtl/mcr_tx_clk_div.sv
`timescale 1ns/1ps
`default_nettype none
module mcr_tx_clk_div
    import mcr_pkg::*;
(
    input wire logic sys_clk, // System clock
    input wire logic rst, // Core reset
    input wire logic clk_en, // Freezes state when low
    input wire logic ref_clk_in, // Sampled reference clock level
    input wire logic [1:0] speed, // Selected speed code
    output logic tx_strobe // One pulse per derived clock period
);
    logic ref_q1;
    logic ref_q2;
    logic ref_q3;
    logic ref_rise;
    logic [MCR_DIV_W-1:0] cnt;
    logic [MCR_DIV_W-1:0] last;

    assign ref_rise = ref_q2 & ~ref_q3;

    always_comb begin
        unique case (speed)
            MCR_SPD_100: last = MCR_DIV_W'(MCR_DIV_100 - 1);
            MCR_SPD_10: last = MCR_DIV_W'(MCR_DIV_10 - 1);
            default: last = '0;
        endcase
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            ref_q1 <= 1'b0;
            ref_q2 <= 1'b0;
            ref_q3 <= 1'b0;
        end else if (clk_en) begin
            ref_q1 <= ref_clk_in;
            ref_q2 <= ref_q1;
            ref_q3 <= ref_q2;
        end
    end

    // Counts reference edges and pulses once per divided period
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            cnt <= '0;
            tx_strobe <= 1'b0;
        end else if (clk_en) begin
            tx_strobe <= 1'b0;
            if (ref_rise) begin
                if (cnt >= last) begin
                    cnt <= '0;
                    tx_strobe <= 1'b1;
                end else begin
                    cnt <= cnt + MCR_DIV_W'(1);
                end
            end
        end
    end
endmodule
`default_nettype wire

// >>> rtl/mcr_top.sv
`timescale 1ns/1ps
`default_nettype none
module mcr_top
    import mcr_pkg::*;
(
    input wire logic sys_clk, // System clock, 200 MHz
    input wire logic reset, // Asynchronous reset, active high
    input wire logic clk_en, // Freezes all state when low
    input wire logic gigabit_tx_ref_clock, // Transmit reference, sampled
    input wire logic clock_lock_in, // Clock lock, high when stable
    input wire mcr_attr_t attr, // Configuration attributes
    input wire logic wb_cyc_i, // Bus cycle
    input wire logic wb_stb_i, // Bus strobe
    input wire logic wb_we_i, // Bus write enable
    input wire logic [MCR_ADR_W-1:0] wb_adr_i, // Byte address
    input wire logic [3:0] wb_sel_i, // Byte enables
    input wire logic [31:0] wb_dat_i, // Write data
    output logic [31:0] wb_dat_o, // Read data
    output logic wb_ack_o, // Bus acknowledge
    output logic mac_in_reset, // MAC core held in reset
    output logic mgmt_serial_active, // Management serial port enabled
    output logic tx_client_wide, // Transmit client path 16 bits
    output logic rx_client_wide, // Receive client path 16 bits
    output mcr_phy_t phy_mode, // Physical interface mode
    output logic [1:0] speed_sel, // Speed code in use
    output logic tx_clk_strobe, // Derived transmit clock pulse
    output logic config_fault // Illegal attribute combination
);
    // ********************************
    // Reset generation
    // ********************************
    logic hold_rst;
    logic core_rst;

    assign hold_rst = reset | ~clock_lock_in;

    mcr_reset_sync u_rst (
        .sys_clk(sys_clk),
        .clk_en(clk_en),
        .async_rst(hold_rst),
        .sync_rst(core_rst)
    );

    // ********************************
    // Decoding functions
    // ********************************
    function automatic logic [1:0] speed_of(input logic msb, input logic lsb);
        return {msb, lsb};
    endfunction

    function automatic logic reg_hit(input logic [MCR_ADR_W-1:0] adr, input logic [MCR_ADR_W-1:0] ofs);
        return adr == ofs;
    endfunction

    // ********************************
    // Load sequence
    // ********************************
    mcr_state_t state;
    mcr_state_t next_state;
    mcr_mode_t mode;
    logic sel_fault;
    logic spd_fault;
    logic [1:0] speed_reg;
    logic mdio_bit;
    logic [2:0] sel_vec;
    mcr_phy_t next_phy;

    assign sel_vec = {attr.reduced_gig_if_select_attr, attr.serial_gig_if_select_attr,
                      attr.fiber_gig_if_select_attr};

    always_comb begin
        unique case (state)
            MCR_ST_HOLD: next_state = MCR_ST_LOAD;
            MCR_ST_LOAD: next_state = MCR_ST_RUN;
            MCR_ST_RUN: next_state = MCR_ST_RUN;
            default: next_state = MCR_ST_HOLD;
        endcase
    end

    // Conflicting selects fall back to MII/GMII
    always_comb begin
        unique case (sel_vec)
            3'h4: next_phy = MCR_PHY_REDUCED;
            3'h2: next_phy = MCR_PHY_SERIAL;
            3'h1: next_phy = MCR_PHY_FIBER;
            default: next_phy = MCR_PHY_MII_GMII;
        endcase
    end

    always_ff @(posedge sys_clk or posedge core_rst) begin
        if (core_rst) begin
            state <= MCR_ST_HOLD;
        end else if (clk_en) begin
            state <= next_state;
        end
    end

    // Mode attributes are captured once, only in the load state
    always_ff @(posedge sys_clk or posedge core_rst) begin
        if (core_rst) begin
            mode <= '{host_en: 1'b0, mdio_attr: 1'b0, tx_wide: 1'b0, rx_wide: 1'b0, phy: MCR_PHY_MII_GMII};
            sel_fault <= 1'b0;
        end else if (clk_en && state == MCR_ST_LOAD) begin
            mode.host_en <= attr.host_interface_enable_attr;
            mode.mdio_attr <= attr.mgmt_serial_enable_attr;
            mode.tx_wide <= attr.tx_wide_client_attr;
            mode.rx_wide <= attr.rx_wide_client_attr;
            mode.phy <= next_phy;
            sel_fault <= (sel_vec != 3'h0) && (next_phy == MCR_PHY_MII_GMII);
        end
    end

    // ********************************
    // Host registers
    // ********************************
    logic bus_req;
    logic wr_mode;
    logic wr_mgmt;
    logic [31:0] mode_word;
    logic [31:0] mgmt_word;
    logic [31:0] stat_word;
    logic [31:0] next_rdata;

    assign bus_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
    // Writes land only when hosted and running
    assign wr_mode = bus_req & wb_we_i & mode.host_en & (state == MCR_ST_RUN)
                     & reg_hit(wb_adr_i, MCR_REG_MODE) & wb_sel_i[3];
    assign wr_mgmt = bus_req & wb_we_i & mode.host_en & (state == MCR_ST_RUN)
                     & reg_hit(wb_adr_i, MCR_REG_MGMT) & wb_sel_i[0];

    // Register defaults come from attributes at load; host may rewrite later
    always_ff @(posedge sys_clk or posedge core_rst) begin
        if (core_rst) begin
            speed_reg <= MCR_SPD_10;
            mdio_bit <= 1'b0;
            spd_fault <= 1'b0;
        end else if (clk_en) begin
            if (state == MCR_ST_LOAD) begin
                speed_reg <= speed_of(attr.speed_msb_attr, attr.speed_lsb_attr);
                mdio_bit <= attr.mgmt_serial_enable_attr;
                spd_fault <= speed_of(attr.speed_msb_attr, attr.speed_lsb_attr) == MCR_SPD_NA;
            end else begin
                if (wr_mode) begin
                    speed_reg <= wb_dat_i[MCR_MODE_SPD_LO+1:MCR_MODE_SPD_LO];
                    spd_fault <= wb_dat_i[MCR_MODE_SPD_LO+1:MCR_MODE_SPD_LO] == MCR_SPD_NA;
                end
                if (wr_mgmt) begin
                    mdio_bit <= wb_dat_i[MCR_MGMT_MDIO];
                end
            end
        end
    end

    always_comb begin
        mode_word = MCR_ZERO_WORD;
        mode_word[MCR_MODE_HOST] = mode.host_en;
        mode_word[MCR_MODE_MDIO_ATTR] = mode.mdio_attr;
        mode_word[MCR_MODE_TXW] = mode.tx_wide;
        mode_word[MCR_MODE_RXW] = mode.rx_wide;
        mode_word[MCR_MODE_PHY_LO+3:MCR_MODE_PHY_LO] = mode.phy;
        mode_word[MCR_MODE_SPD_LO+1:MCR_MODE_SPD_LO] = speed_reg;
        mgmt_word = MCR_ZERO_WORD;
        mgmt_word[MCR_MGMT_MDIO] = mdio_bit;
        stat_word = MCR_ZERO_WORD;
        stat_word[MCR_STAT_LOCK] = clock_lock_in;
        stat_word[MCR_STAT_RUN] = state == MCR_ST_RUN;
        stat_word[MCR_STAT_SEL_FAULT] = sel_fault;
        stat_word[MCR_STAT_SPD_FAULT] = spd_fault;
    end

    // Disabled host interface reads as zero; unmapped addresses too
    always_comb begin
        next_rdata = MCR_ZERO_WORD;
        if (mode.host_en) begin
            if (reg_hit(wb_adr_i, MCR_REG_MODE)) begin
                next_rdata = mode_word;
            end else if (reg_hit(wb_adr_i, MCR_REG_MGMT)) begin
                next_rdata = mgmt_word;
            end else if (reg_hit(wb_adr_i, MCR_REG_STAT)) begin
                next_rdata = stat_word;
            end
        end
    end

    always_ff @(posedge sys_clk or posedge core_rst) begin
        if (core_rst) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= MCR_ZERO_WORD;
        end else if (clk_en) begin
            wb_ack_o <= bus_req;
            if (bus_req && !wb_we_i) begin
                wb_dat_o <= next_rdata;
            end
        end
    end

    // ********************************
    // Mode outputs
    // ********************************
    logic [1:0] speed_eff;

    // Unused speed pattern runs as gigabit
    assign speed_eff = (speed_reg == MCR_SPD_NA) ? MCR_SPD_1000 : speed_reg;

    always_ff @(posedge sys_clk or posedge core_rst) begin
        if (core_rst) begin
            mac_in_reset <= 1'b1;
            mgmt_serial_active <= 1'b0;
            tx_client_wide <= 1'b0;
            rx_client_wide <= 1'b0;
            phy_mode <= MCR_PHY_MII_GMII;
            speed_sel <= MCR_SPD_10;
            config_fault <= 1'b0;
        end else if (clk_en) begin
            mac_in_reset <= next_state != MCR_ST_RUN;
            if (mode.host_en) begin
                mgmt_serial_active <= mode.mdio_attr & mdio_bit;
            end else begin
                mgmt_serial_active <= mode.mdio_attr;
            end
            tx_client_wide <= mode.tx_wide;
            rx_client_wide <= mode.rx_wide;
            phy_mode <= mode.phy;
            speed_sel <= speed_eff;
            config_fault <= sel_fault | spd_fault;
        end
    end

    // ********************************
    // Transmit clock derivation
    // ********************************
    mcr_tx_clk_div u_div (
        .sys_clk(sys_clk),
        .rst(core_rst),
        .clk_en(clk_en),
        .ref_clk_in(gigabit_tx_ref_clock),
        .speed(speed_eff),
        .tx_strobe(tx_clk_strobe)
    );
endmodule
`default_nettype wire

// >>> testbench/mcr_partner.sv
`timescale 1ns/1ps
`default_nettype none
module mcr_partner
    import mcr_pkg::*;
(
    input wire logic sys_clk, // Clock
    input wire logic clock_manager_lock, // Manager lock
    input wire logic transceiver_pll_lock, // PLL lock
    output logic gigabit_tx_ref_clock, // Reference clock
    output logic clock_lock_in // Lock to the MAC
);
    // ************
    // Reference and lock
    // ************
    logic [1:0] phase = 2'h0;
    always_ff @(posedge sys_clk) begin
        phase <= phase + 2'h1;
    end
    // Period of four system clocks, slow enough to be sampled
    assign gigabit_tx_ref_clock = phase[1];
    assign clock_lock_in = clock_manager_lock & transceiver_pll_lock;
endmodule
`default_nettype wire

// >>> testbench/mcr_top_sva.sv
`timescale 1ns/1ps
`default_nettype none
module mcr_top_sva
    import mcr_pkg::*;
(
    input wire logic sys_clk, // Clock
    input wire logic reset, // Reset
    input wire logic clk_en, // Enable
    input wire logic gigabit_tx_ref_clock, // Reference
    input wire logic clock_lock_in, // Lock
    input wire mcr_attr_t attr, // Attributes
    input wire logic wb_cyc_i, // Cycle
    input wire logic wb_stb_i, // Strobe
    input wire logic wb_ack_o, // Ack
    input wire logic mac_in_reset, // Core reset
    input wire logic mgmt_serial_active, // Serial on
    input wire logic tx_client_wide, // Tx wide
    input wire logic rx_client_wide, // Rx wide
    input wire mcr_phy_t phy_mode, // Phy mode
    input wire logic [1:0] speed_sel, // Speed
    input wire logic tx_clk_strobe // Tx pulse
);
    // ************
    // Reset, load, bus and transmit strobe checks
    // ************
    default clocking cb @(posedge sys_clk);
    endclocking
    property p_async_reset;
        reset || !clock_lock_in |-> mac_in_reset && !wb_ack_o && !tx_clk_strobe;
    endproperty
    a_async_reset: assert property (p_async_reset) else $error("Core active during reset");
    property p_release;
        disable iff (reset || !clock_lock_in) $fell(reset || !clock_lock_in) |-> mac_in_reset [*4] ##1 !mac_in_reset;
    endproperty
    a_release: assert property (p_release) else $error("Core reset released at wrong edge");
    property p_mode_fixed;
        disable iff (reset || !clock_lock_in) !mac_in_reset && !$past(mac_in_reset, 2)
            |-> $stable(tx_client_wide) && $stable(rx_client_wide) && $stable(phy_mode);
    endproperty
    a_mode_fixed: assert property (p_mode_fixed) else $error("Mode changed while running");
    property p_width_load;
        disable iff (reset || !clock_lock_in) $fell(mac_in_reset) |-> ##[0:2] tx_client_wide == attr[6] && rx_client_wide == attr[5];
    endproperty
    a_width_load: assert property (p_width_load) else $error("Client width not loaded");
    property p_phy_load;
        disable iff (reset || !clock_lock_in) $fell(mac_in_reset) |-> ##[0:2] phy_mode == (attr[4:2] == 3'h4 ? MCR_PHY_REDUCED :
            attr[4:2] == 3'h2 ? MCR_PHY_SERIAL : attr[4:2] == 3'h1 ? MCR_PHY_FIBER : MCR_PHY_MII_GMII);
    endproperty
    a_phy_load: assert property (p_phy_load) else $error("Interface mode not loaded");
    property p_mgmt_load;
        disable iff (reset || !clock_lock_in) $fell(mac_in_reset) |-> ##[0:2] mgmt_serial_active == attr[7];
    endproperty
    a_mgmt_load: assert property (p_mgmt_load) else $error("Serial management not loaded");
    property p_bus_ack;
        disable iff (reset || !clock_lock_in) wb_cyc_i && wb_stb_i && !wb_ack_o && clk_en |=> wb_ack_o ##1 !wb_ack_o;
    endproperty
    a_bus_ack: assert property (p_bus_ack) else $error("Bus ack not a single cycle pulse");
    property p_gig_strobe;
        disable iff (reset || !clock_lock_in) $rose(gigabit_tx_ref_clock) && speed_sel == MCR_SPD_1000 && !mac_in_reset
            |-> ##[1:5] tx_clk_strobe || speed_sel != MCR_SPD_1000;
    endproperty
    a_gig_strobe: assert property (p_gig_strobe) else $error("No transmit pulse for reference edge");
endmodule
bind mcr_top mcr_top_sva u_sva (.*);
`default_nettype wire

// >>> testbench/testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench
    import mcr_pkg::*;
;
    // ************
    // Signals and models
    // ************
    logic sys_clk, clk_en = 1'b1, reset = 1'b1, clock_manager_lock = 1'b1, transceiver_pll_lock = 1'b1;
    logic gigabit_tx_ref_clock, clock_lock_in, wb_ack_o, mac_in_reset, mgmt_serial_active, tx_client_wide;
    logic rx_client_wide, tx_clk_strobe, config_fault, wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
    logic [MCR_ADR_W-1:0] wb_adr_i = 4'h0;
    logic [3:0] wb_sel_i = 4'h0;
    logic [31:0] wb_dat_i = 32'h0, wb_dat_o, rd, seed = 32'h3438;
    logic [1:0] speed_sel;
    mcr_phy_t phy_mode;
    mcr_attr_t attr = 9'h0;
    mcr_attr_t corner [5] = '{9'h1C2, 9'h0B1, 9'h16F, 9'h004, 9'h188};
    int err_count = 0, check_count = 0;
    mcr_top uut (.*);
    mcr_partner u_partner (.*);
    // ************
    // Helpers
    // ************
    function automatic logic [31:0] f_lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    // Expected tx, rx, phy, speed, fault and serial outputs after load
    function automatic logic [31:0] f_out(input mcr_attr_t a);
        logic [3:0] p;
        p = (a[4:2] == 3'h4) ? 4'h2 : (a[4:2] == 3'h2) ? 4'h4 : (a[4:2] == 3'h1) ? 4'h8 : 4'h1;
        return {22'h0, a[6], a[5], p, a[1], a[0] & ~a[1], ($countones(a[4:2]) > 1) | (&a[1:0]), a[7]};
    endfunction
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            err_count++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wb(input logic w, input logic [MCR_ADR_W-1:0] a, input logic [3:0] s, input logic [31:0] d);
        int n;
        n = 0;
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= w;
        wb_adr_i <= a;
        wb_sel_i <= s;
        wb_dat_i <= d;
        // Ack and data are looked at where settled, request released on the next rising edge
        do begin
            @(negedge sys_clk);
            n++;
        end while (wb_ack_o !== 1'b1 && n < 20);
        rd = wb_dat_o;
        @(posedge sys_clk);
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        if (n >= 20) chk(32'h0, 32'h1);
        @(posedge sys_clk);
    endtask
    task automatic stop_test();
        $display("Comparisons %0d, mismatches %0d", check_count, err_count);
        if (err_count == 0 && check_count > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    // ************
    // Sequence
    // ************
    initial begin
        sys_clk = 1'b0;
        forever #2.5 sys_clk = ~sys_clk;
    end
    initial begin
        #100000;
        chk(32'h0, 32'h1);
        stop_test();
    end
    initial begin
        mcr_attr_t cur;
        logic [31:0] e;
        logic [31:0] snap;
        int n;
        int k;
        repeat (10) @(posedge sys_clk);
        for (int i = 0; i < 10; i++) begin
            cur = (i < 5) ? corner[i] : mcr_attr_t'(seed[8:0]);
            seed = f_lfsr(seed);
            e = f_out(cur);
            attr <= cur;
            if (i % 3 == 0) reset <= 1'b1;
            else if (i % 3 == 1) clock_manager_lock <= 1'b0;
            else transceiver_pll_lock <= 1'b0;
            repeat (2) @(posedge sys_clk);
            chk(32'(mac_in_reset), 32'h1);
            reset <= 1'b0;
            clock_manager_lock <= 1'b1;
            transceiver_pll_lock <= 1'b1;
            n = 0;
            while (mac_in_reset !== 1'b0 && n < 20) begin
                @(posedge sys_clk);
                n++;
            end
            repeat (3) @(posedge sys_clk);
            chk(32'({tx_client_wide, rx_client_wide, phy_mode, speed_sel, config_fault, mgmt_serial_active}), e);
            k = (e[3:2] == 2'h2) ? 100 : (e[3:2] == 2'h1) ? 20 : 2;
            n = 0;
            repeat (400) begin
                @(posedge sys_clk);
                if (tx_clk_strobe === 1'b1) n++;
            end
            chk(32'(n >= k - 1 && n <= k + 1), 32'h1);
            wb(1'b0, MCR_REG_MODE, 4'hF, 32'h0);
            chk(rd, {32{cur[8]}} & {cur[1:0], 22'h0, e[7:4], cur[5], cur[6], cur[7], cur[8]});
            wb(1'b0, MCR_REG_MGMT, 4'hF, 32'h0);
            chk(rd, {32{cur[8]}} & {25'h0, cur[7], 6'h0});
            wb(1'b0, MCR_REG_STAT, 4'hF, 32'h0);
            chk(rd, {32{cur[8]}} & {28'h0, &cur[1:0], $countones(cur[4:2]) > 1, 2'h3});
            wb(1'b0, 4'hC, 4'hF, 32'h0);
            chk(rd, 32'h0);
            wb(1'b1, MCR_REG_MGMT, 4'h1, 32'h0);
            @(posedge sys_clk);
            chk(32'(mgmt_serial_active), 32'(cur[7] & ~cur[8]));
            wb(1'b1, MCR_REG_MGMT, 4'h1, 32'h40);
            @(posedge sys_clk);
            chk(32'(mgmt_serial_active), 32'(cur[7]));
            // Low mode bits written as zero must not move the fixed mode
            wb(1'b1, MCR_REG_MODE, 4'h8, 32'h4000_0000);
            attr <= ~cur;
            repeat (3) @(posedge sys_clk);
            chk(32'({tx_client_wide, rx_client_wide, phy_mode, speed_sel}), 32'({e[9:4], cur[8] ? 2'h1 : e[3:2]}));
            // Low clock enable must freeze every output, read data checked on its low byte only
            if (cur[8]) begin
                clk_en <= 1'b0;
                repeat (2) @(posedge sys_clk);
                snap = 32'({mac_in_reset, mgmt_serial_active, tx_client_wide, rx_client_wide, phy_mode, speed_sel,
                            config_fault, tx_clk_strobe, wb_ack_o, wb_dat_o[7:0]});
                repeat (20) @(posedge sys_clk);
                chk(32'({mac_in_reset, mgmt_serial_active, tx_client_wide, rx_client_wide, phy_mode, speed_sel,
                         config_fault, tx_clk_strobe, wb_ack_o, wb_dat_o[7:0]}), snap);
                clk_en <= 1'b1;
            end
        end
        stop_test();
    end
endmodule
`default_nettype wire
